// file: nfc_ctrl.v
// Overview of operation
// - Read is 00h plus four address cycles
// - Each strobe fall gives next byte, 50ns; this controller strobes once every 5 clocks, 100ns
// - Chip select high ends sequential read
// - Spare pointer persists until main command
// - Host stops sequential read at block end
// - Host limits partial page program counts; this controller does not count them
// - Program is 80h, address, data, 10h
// - Erase is 60h, three addresses, D0h
// - 11h ends plane load, 10h programs all
// - Multi-plane uses at most four planes
// - Status may be polled during plane switch
// - No multi-plane program with pointer 01h
`include "nfc_defines.vh"

module nfc_ctrl (
    // APB slave
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output wire        pslverr,
    output reg  [31:0] prdata,
    // Flash pins
    output reg         nand_ce_n,
    output reg         nand_cle,
    output reg         nand_ale,
    output reg         nand_we_n,
    output reg         output_strobe_n,
    input  wire        nand_rb,
    input  wire [7:0]  nand_io_in,
    output reg  [7:0]  nand_io_out,
    output reg         nand_io_oe
);

    localparam S_IDLE  = 4'h0;
    localparam S_PTR   = 4'h1;
    localparam S_CMD   = 4'h2;
    localparam S_ADDR  = 4'h3;
    localparam S_WDATA = 4'h4;
    localparam S_CONF  = 4'h5;
    localparam S_WB    = 4'h6;
    localparam S_BUSY  = 4'h7;
    localparam S_STCMD = 4'h8;
    localparam S_RDATA = 4'h9;
    localparam S_END   = 4'hA;

    reg [3:0]  state_reg;
    reg [2:0]  tmr_reg;
    reg [9:0]  cnt_reg;
    reg [1:0]  acnt_reg;
    reg [9:0]  col_reg;
    reg [4:0]  page_reg;
    reg [2:0]  op_reg;
    reg [1:0]  area_reg;
    reg [1:0]  ptr_area_reg;
    reg        mp_reg;
    reg        last_reg;
    reg [2:0]  plane_cnt_reg;
    reg        status_mode_reg;
    reg        block_end_reg;
    reg        done_reg;
    reg        err_reg;
    reg [7:0]  stat_byte_reg;
    reg [31:0] addr_reg;
    reg [9:0]  len_reg;
    reg [9:0]  bptr_reg;
    reg        bwait_reg;

    wire       busy      = (state_reg != S_IDLE);
    wire       access    = psel & penable;
    wire       mapped    = (paddr == `NFC_CTRL_OFF) | (paddr == `NFC_ADDR_OFF) |
                           (paddr == `NFC_LEN_OFF) | (paddr == `NFC_STAT_OFF) |
                           (paddr == `NFC_BPTR_OFF) | (paddr == `NFC_BDATA_OFF);
    wire       locked    = busy & ((paddr == `NFC_CTRL_OFF) | (paddr == `NFC_BDATA_OFF));
    // Reads take one wait state so prdata comes from a flop
    assign pready  = pwrite | bwait_reg;
    assign pslverr = access & pready & (~mapped | locked);
    wire       wr_ok     = access & pwrite & mapped & ~locked;
    wire       rd_done   = access & ~pwrite & bwait_reg & mapped & ~locked;

    wire [2:0] req_op    = pwdata[`NFC_CTRL_OP_HI:`NFC_CTRL_OP_LO];
    wire [1:0] req_area  = pwdata[`NFC_CTRL_AREA_HI:`NFC_CTRL_AREA_LO];
    wire       req_mp    = pwdata[`NFC_CTRL_MP_BIT];
    wire       len_ok    = (len_reg != 10'h0000) && (len_reg <= `NFC_PAGE_BYTES);
    wire       st_op     = (req_op == `NFC_OP_STATUS) | (req_op == `NFC_OP_MP_STATUS) |
                           (req_op == `NFC_OP_RESET);
    reg        op_ok;
    always @* begin
        case (req_op)
            `NFC_OP_READ:      op_ok = len_ok && (req_area != 2'h3);
            `NFC_OP_ADDR_READ: op_ok = len_ok && !status_mode_reg;
            `NFC_OP_PROG:      op_ok = len_ok && (req_area != 2'h3) &&
                                       !(req_mp && req_area == `NFC_AREA_B) &&
                                       !(req_mp && plane_cnt_reg == `NFC_MAX_PLANES);
            `NFC_OP_ERASE:     op_ok = 1'b1;
            `NFC_OP_STATUS:    op_ok = 1'b1;
            `NFC_OP_MP_STATUS: op_ok = 1'b1;
            `NFC_OP_RESET:     op_ok = 1'b1;
            default:           op_ok = 1'b0;
        endcase
    end
    wire       start_req = wr_ok & (paddr == `NFC_CTRL_OFF);
    wire       start     = start_req & op_ok & (nand_rb | st_op);
    wire       refuse    = start_req & ~start;

    // Start column from pointer area and low address byte
    wire [1:0] eff_area  = (req_op == `NFC_OP_ADDR_READ) ? ptr_area_reg : req_area;
    reg  [9:0] col_start;
    always @* begin
        case (eff_area)
            `NFC_AREA_B: col_start = `NFC_HALF_BASE + {2'h0, addr_reg[7:0]};
            `NFC_AREA_C: col_start = `NFC_SPARE_BASE + {6'h00, addr_reg[3:0]};
            default:     col_start = {2'h0, addr_reg[7:0]};
        endcase
    end

    wire       is_read   = (op_reg == `NFC_OP_READ) | (op_reg == `NFC_OP_ADDR_READ);
    wire       strobe_lo = (tmr_reg >= 3'h1) && (tmr_reg <= `NFC_HALF_CYC);
    wire       strobe_end = (tmr_reg == 2 * `NFC_HALF_CYC);
    wire       sample    = (state_reg == S_RDATA) && (tmr_reg == `NFC_HALF_CYC + 1);
    wire       wr_state  = (state_reg == S_PTR) | (state_reg == S_CMD) |
                           (state_reg == S_ADDR) | (state_reg == S_WDATA) |
                           (state_reg == S_CONF) | (state_reg == S_STCMD);
    wire [7:0] buf_rdata;

    reg  [7:0] ptr_byte;
    reg  [7:0] io_byte;
    always @* begin
        case (area_reg)
            `NFC_AREA_B: ptr_byte = `NFC_CMD_READ_B;
            `NFC_AREA_C: ptr_byte = `NFC_CMD_READ_C;
            default:     ptr_byte = `NFC_CMD_READ_A;
        endcase
        case (state_reg)
            S_PTR:   io_byte = ptr_byte;
            S_CMD:   io_byte = (op_reg == `NFC_OP_PROG)  ? `NFC_CMD_PROG :
                               (op_reg == `NFC_OP_ERASE) ? `NFC_CMD_ERASE :
                               (op_reg == `NFC_OP_RESET) ? `NFC_CMD_RESET : ptr_byte;
            S_ADDR:  io_byte = (acnt_reg == 2'h0) ? addr_reg[7:0] :
                               (acnt_reg == 2'h1) ? addr_reg[15:8] :
                               (acnt_reg == 2'h2) ? addr_reg[23:16] : addr_reg[31:24];
            S_WDATA: io_byte = buf_rdata;
            S_CONF:  io_byte = (op_reg == `NFC_OP_ERASE) ? `NFC_CMD_ERASE_CONF :
                               (mp_reg && !last_reg) ? `NFC_CMD_PROG_DUMMY :
                               `NFC_CMD_PROG_CONF;
            S_STCMD: io_byte = ((op_reg == `NFC_OP_MP_STATUS) ||
                                (op_reg == `NFC_OP_PROG && mp_reg))
                               ? `NFC_CMD_MP_STATUS : `NFC_CMD_STATUS;
            default: io_byte = 8'h00;
        endcase
    end

    // Pins registered from the decoded state
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nand_ce_n       <= 1'b1;
            nand_cle        <= 1'b0;
            nand_ale        <= 1'b0;
            nand_we_n       <= 1'b1;
            output_strobe_n <= 1'b1;
            nand_io_out     <= 8'h00;
            nand_io_oe      <= 1'b0;
        end else begin
            nand_ce_n       <= (state_reg == S_IDLE) | (state_reg == S_END);
            nand_cle        <= (state_reg == S_PTR) | (state_reg == S_CMD) |
                               (state_reg == S_CONF) | (state_reg == S_STCMD);
            nand_ale        <= (state_reg == S_ADDR);
            nand_we_n       <= ~(wr_state & strobe_lo);
            output_strobe_n <= ~((state_reg == S_RDATA) & strobe_lo);
            nand_io_out     <= io_byte;
            nand_io_oe      <= wr_state;
        end
    end

    // Sequencer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg       <= S_IDLE;
            tmr_reg         <= 3'h0;
            cnt_reg         <= 10'h0000;
            acnt_reg        <= 2'h0;
            col_reg         <= 10'h0000;
            page_reg        <= 5'h00;
            op_reg          <= 3'h0;
            area_reg        <= `NFC_AREA_A;
            ptr_area_reg    <= `NFC_AREA_A;
            mp_reg          <= 1'b0;
            last_reg        <= 1'b0;
            plane_cnt_reg   <= 3'h0;
            status_mode_reg <= 1'b0;
            block_end_reg   <= 1'b0;
            stat_byte_reg   <= 8'h00;
        end else begin
            case (state_reg)
                S_IDLE: begin
                    tmr_reg <= 3'h0;
                    if (start) begin
                        op_reg   <= req_op;
                        area_reg <= req_area;
                        mp_reg   <= req_mp;
                        last_reg <= pwdata[`NFC_CTRL_LAST_BIT];
                        cnt_reg  <= 10'h0000;
                        col_reg  <= col_start;
                        page_reg <= addr_reg[12:8];
                        acnt_reg <= (req_op == `NFC_OP_ERASE) ? 2'h1 : 2'h0;
                        if (req_op == `NFC_OP_READ || req_op == `NFC_OP_ADDR_READ) begin
                            block_end_reg <= 1'b0;
                        end
                        case (req_op)
                            `NFC_OP_ADDR_READ: state_reg <= S_ADDR;
                            `NFC_OP_PROG:      state_reg <= S_PTR;
                            `NFC_OP_STATUS:    state_reg <= S_STCMD;
                            `NFC_OP_MP_STATUS: state_reg <= S_STCMD;
                            default:           state_reg <= S_CMD;
                        endcase
                    end
                end
                S_PTR, S_CMD, S_ADDR, S_WDATA, S_CONF, S_STCMD: begin
                    tmr_reg <= strobe_end ? 3'h0 : tmr_reg + 3'h1;
                    if (strobe_end) begin
                        case (state_reg)
                            S_PTR: begin
                                ptr_area_reg <= area_reg;
                                state_reg    <= S_CMD;
                            end
                            S_CMD: begin
                                status_mode_reg <= 1'b0;
                                if (op_reg == `NFC_OP_READ) begin
                                    ptr_area_reg <= area_reg;
                                end
                                if (op_reg == `NFC_OP_RESET) begin
                                    ptr_area_reg  <= `NFC_AREA_A;
                                    plane_cnt_reg <= 3'h0;
                                end
                                state_reg <= (op_reg == `NFC_OP_RESET) ? S_WB : S_ADDR;
                            end
                            S_ADDR: begin
                                acnt_reg <= acnt_reg + 2'h1;
                                if (acnt_reg == 2'h3) begin
                                    state_reg <= is_read ? S_WB :
                                                 (op_reg == `NFC_OP_PROG) ? S_WDATA : S_CONF;
                                end
                            end
                            S_WDATA: begin
                                cnt_reg <= cnt_reg + 10'h0001;
                                if (cnt_reg == len_reg - 10'h0001) begin
                                    state_reg <= S_CONF;
                                end
                            end
                            S_CONF:  state_reg <= S_WB;
                            default: begin
                                status_mode_reg <= 1'b1;
                                state_reg       <= S_RDATA;
                            end
                        endcase
                    end
                end
                S_WB: begin
                    // Busy only shows a while after the last strobe
                    tmr_reg <= tmr_reg + 3'h1;
                    if (tmr_reg == `NFC_WB_CYC - 1) begin
                        tmr_reg   <= 3'h0;
                        state_reg <= S_BUSY;
                    end
                end
                S_BUSY: begin
                    if (nand_rb) begin
                        if (is_read) begin
                            state_reg <= S_RDATA;
                        end else if (op_reg == `NFC_OP_RESET) begin
                            state_reg <= S_END;
                        end else if (op_reg == `NFC_OP_PROG && mp_reg && !last_reg) begin
                            plane_cnt_reg <= plane_cnt_reg + 3'h1;
                            state_reg     <= S_END;
                        end else begin
                            if (op_reg == `NFC_OP_PROG) begin
                                plane_cnt_reg <= 3'h0;
                            end
                            state_reg <= S_STCMD;
                        end
                    end
                end
                S_RDATA: begin
                    tmr_reg <= strobe_end ? 3'h0 : tmr_reg + 3'h1;
                    if (sample && !is_read) begin
                        stat_byte_reg <= nand_io_in;
                    end
                    if (strobe_end) begin
                        if (!is_read) begin
                            state_reg <= S_END;
                        end else begin
                            cnt_reg <= cnt_reg + 10'h0001;
                            col_reg <= col_reg + 10'h0001;
                            if (cnt_reg == len_reg - 10'h0001) begin
                                state_reg <= S_END;
                            end else if (col_reg == `NFC_LAST_COL) begin
                                if (page_reg == `NFC_LAST_PAGE) begin
                                    block_end_reg <= 1'b1;
                                    state_reg     <= S_END;
                                end else begin
                                    // Device reloads the next page on its own
                                    page_reg  <= page_reg + 5'h01;
                                    col_reg   <= (ptr_area_reg == `NFC_AREA_C) ?
                                                 `NFC_SPARE_BASE : 10'h0000;
                                    if (ptr_area_reg == `NFC_AREA_B) begin
                                        ptr_area_reg <= `NFC_AREA_A;
                                    end
                                    state_reg <= S_WB;
                                end
                            end
                        end
                    end
                end
                S_END: begin
                    if (ptr_area_reg == `NFC_AREA_B && op_reg != `NFC_OP_STATUS &&
                        op_reg != `NFC_OP_MP_STATUS) begin
                        ptr_area_reg <= `NFC_AREA_A;
                    end
                    state_reg <= S_IDLE;
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end

    // Software registers; hardware set beats the clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_reg  <= 32'h0000_0000;
            len_reg   <= `NFC_LEN_RESET;
            bptr_reg  <= 10'h0000;
            bwait_reg <= 1'b0;
            prdata    <= 32'h0000_0000;
            done_reg  <= 1'b0;
            err_reg   <= 1'b0;
        end else begin
            bwait_reg <= access & ~pwrite & ~bwait_reg;
            if (wr_ok && paddr == `NFC_ADDR_OFF) begin
                addr_reg <= pwdata;
            end
            if (wr_ok && paddr == `NFC_LEN_OFF) begin
                len_reg <= pwdata[9:0];
            end
            if (wr_ok && paddr == `NFC_BPTR_OFF) begin
                bptr_reg <= pwdata[9:0];
            end else if ((wr_ok || rd_done) && paddr == `NFC_BDATA_OFF) begin
                bptr_reg <= bptr_reg + 10'h0001;
            end
            if (state_reg == S_END) begin
                done_reg <= 1'b1;
            end else if (wr_ok && paddr == `NFC_STAT_OFF && pwdata[`NFC_STAT_DONE_BIT]) begin
                done_reg <= 1'b0;
            end
            if (refuse) begin
                err_reg <= 1'b1;
            end else if (wr_ok && paddr == `NFC_STAT_OFF && pwdata[`NFC_STAT_ERR_BIT]) begin
                err_reg <= 1'b0;
            end
            if (access && !pwrite && !bwait_reg) begin
                case (paddr)
                    `NFC_CTRL_OFF:  prdata <= {29'h0000_0000, op_reg};
                    `NFC_ADDR_OFF:  prdata <= addr_reg;
                    `NFC_LEN_OFF:   prdata <= {22'h00_0000, len_reg};
                    `NFC_STAT_OFF:  prdata <= {8'h00, stat_byte_reg, 5'h00, plane_cnt_reg,
                                               ptr_area_reg, status_mode_reg, nand_rb,
                                               block_end_reg, err_reg, done_reg, busy};
                    `NFC_BPTR_OFF:  prdata <= {22'h00_0000, bptr_reg};
                    `NFC_BDATA_OFF: prdata <= {24'h00_0000, buf_rdata};
                    default:        prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    wire       buf_we    = busy ? (sample & is_read) :
                           (wr_ok & (paddr == `NFC_BDATA_OFF));
    wire [9:0] buf_waddr = busy ? cnt_reg : bptr_reg;
    wire [7:0] buf_wdata = busy ? nand_io_in : pwdata[7:0];

    nfc_page_buf u_buf (
        .pclk  (pclk),
        .we    (buf_we),
        .waddr (buf_waddr),
        .wdata (buf_wdata),
        .raddr (busy ? cnt_reg : bptr_reg),
        .rdata (buf_rdata)
    );

endmodule // nfc_ctrl

// file: nfc_defines.vh
`ifndef NFC_DEFINES_VH
`define NFC_DEFINES_VH

// Register offsets
`define NFC_CTRL_OFF       8'h00
`define NFC_ADDR_OFF       8'h04
`define NFC_LEN_OFF        8'h08
`define NFC_STAT_OFF       8'h0C
`define NFC_BPTR_OFF       8'h10
`define NFC_BDATA_OFF      8'h14

// Control fields
`define NFC_CTRL_OP_HI     2
`define NFC_CTRL_OP_LO     0
`define NFC_CTRL_AREA_HI   5
`define NFC_CTRL_AREA_LO   4
`define NFC_CTRL_MP_BIT    8
`define NFC_CTRL_LAST_BIT  9

// Status fields
`define NFC_STAT_DONE_BIT  1
`define NFC_STAT_ERR_BIT   2
`define NFC_STAT_BEND_BIT  3

// Operations
`define NFC_OP_READ        3'h1
`define NFC_OP_ADDR_READ   3'h2
`define NFC_OP_PROG        3'h3
`define NFC_OP_ERASE       3'h4
`define NFC_OP_STATUS      3'h5
`define NFC_OP_MP_STATUS   3'h6
`define NFC_OP_RESET       3'h7

// Pointer areas
`define NFC_AREA_A         2'h0
`define NFC_AREA_B         2'h1
`define NFC_AREA_C         2'h2

// Device commands
`define NFC_CMD_READ_A     8'h00
`define NFC_CMD_READ_B     8'h01
`define NFC_CMD_READ_C     8'h50
`define NFC_CMD_PROG       8'h80
`define NFC_CMD_PROG_CONF  8'h10
`define NFC_CMD_PROG_DUMMY 8'h11
`define NFC_CMD_ERASE      8'h60
`define NFC_CMD_ERASE_CONF 8'hD0
`define NFC_CMD_STATUS     8'h70
`define NFC_CMD_MP_STATUS  8'h71
`define NFC_CMD_RESET      8'hFF

// Page geometry
`define NFC_PAGE_BYTES     10'h0210
`define NFC_LAST_COL       10'h020F
`define NFC_HALF_BASE      10'h0100
`define NFC_SPARE_BASE     10'h0200
`define NFC_LAST_PAGE      5'h1F
`define NFC_MAX_PLANES     3'h4
`define NFC_LEN_RESET      10'h0210

// Timing
`define NFC_CLK_NS         20
`define NFC_STROBE_NS      60
`define NFC_HALF_CYC       ((`NFC_STROBE_NS + 2 * `NFC_CLK_NS - 1) / (2 * `NFC_CLK_NS))
`define NFC_WB_NS          100
`define NFC_WB_CYC         ((`NFC_WB_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS)

`endif

// file: nfc_page_buf.v
module nfc_page_buf (
    // Clock
    input  wire       pclk,
    // Write port
    input  wire       we,
    input  wire [9:0] waddr,
    input  wire [7:0] wdata,
    // Read port
    input  wire [9:0] raddr,
    output reg  [7:0] rdata
);

    reg [7:0] mem [0:527];

    // No reset: contents are only meaningful after a load
    always @(posedge pclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end

endmodule // nfc_page_buf

// file: nfc_ctrl_asserts.sv
module nfc_ctrl_asserts (
    // APB
    input logic       pclk,
    input logic       presetn,
    input logic       psel,
    input logic       penable,
    input logic       pwrite,
    input logic       pready,
    // Flash pins
    input logic       nand_ce_n,
    input logic       nand_cle,
    input logic       nand_ale,
    input logic       nand_we_n,
    input logic       output_strobe_n,
    input logic       nand_rb,
    input logic [7:0] nand_io_out,
    input logic       nand_io_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_rd_wait: assert property ($rose(penable) && psel && !pwrite |-> !pready ##1 pready)
        else $error("read wait state wrong");
    chk_we_width: assert property ($fell(nand_we_n) |=> !nand_we_n ##1 nand_we_n)
        else $error("write strobe width wrong");
    chk_re_cycle: assert property ($fell(output_strobe_n) |=> !output_strobe_n
        ##1 output_strobe_n ##1 output_strobe_n)
        else $error("read strobe cycle too short");
    chk_ce_held: assert property (!output_strobe_n || !nand_we_n |-> !nand_ce_n)
        else $error("strobe without chip select");
    chk_oe_off: assert property (!output_strobe_n |-> !nand_io_oe && nand_we_n)
        else $error("driving bus while reading");
    chk_latch_excl: assert property (nand_cle |-> !nand_ale)
        else $error("command and address latch together");
    chk_busy_cmds: assert property ($rose(nand_we_n) && nand_cle && !nand_rb |->
        nand_io_out inside {8'h70, 8'h71, 8'hFF})
        else $error("command sent while busy");
    chk_conf_wait: assert property ($rose(nand_we_n) && nand_cle && nand_io_out == 8'h10 |->
        (nand_we_n && output_strobe_n) [*5])
        else $error("strobe too soon after confirm");
endmodule // nfc_ctrl_asserts

bind nfc_ctrl nfc_ctrl_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pready(pready), .nand_ce_n(nand_ce_n),
    .nand_cle(nand_cle), .nand_ale(nand_ale), .nand_we_n(nand_we_n),
    .output_strobe_n(output_strobe_n), .nand_rb(nand_rb), .nand_io_out(nand_io_out),
    .nand_io_oe(nand_io_oe));

// file: nfc_dev_model.sv
module nfc_dev_model #(
    parameter int LOAD_CYC = 600,
    parameter int PROG_CYC = 300
) (
    // Host side
    input  logic       pclk,
    input  logic       ce_n,
    input  logic       cle,
    input  logic       ale,
    input  logic       we_n,
    input  logic       re_n,
    input  logic [7:0] din,
    // Fault injection
    input  logic       fail,
    // Device outputs
    output logic       rb,
    output logic [7:0] dout
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       we_q = 1, re_q = 1, stat = 0, ld = 0;
    logic [1:0] ptr = 0;
    logic [2:0] ac = 0;
    logic [7:0] cmd = 0, pg = 0, dout_r = 0;
    logic [9:0] col = 0;
    int         bc = 0;
    assign rb = (bc == 0);
    assign dout = dout_r;
    always @(posedge pclk) begin
        we_q <= we_n;
        re_q <= re_n;
        if (bc > 0) bc <= bc - 1;
        if (ce_n) ac <= 0;
        if (!ce_n && we_n && !we_q) begin
            if (cle && (rb || din inside {8'h70, 8'h71, 8'hFF})) begin
                cmd <= din;
                ac <= 0;
                stat <= din inside {8'h70, 8'h71};
                if (din inside {8'h00, 8'h01, 8'h50}) ptr <= (din == 8'h50) ? 2'd2 : din[1:0];
                if (din == 8'h80) ld <= 0;
                if ((din == 8'h10 && ld) || din == 8'hD0) bc <= PROG_CYC;
                if (din == 8'h11 && ld) bc <= 20;
            end else if (ale) begin
                ac <= ac + 1;
                if (ac == 0) col <= (ptr == 2) ? {6'h20, din[3:0]} : {1'b0, ptr[0], din};
                if (ac == 1) pg <= din;
                if (ac == 3 && cmd inside {8'h00, 8'h01, 8'h50}) bc <= LOAD_CYC;
                if (ac == 3 && ptr == 1) ptr <= 0;
            end else if (cmd == 8'h80) ld <= 1;
        end
        // Released bus keeps toggling so a stale byte never looks valid
        if (ce_n || re_n) dout_r <= ~dout_r;
        else if (stat) dout_r <= {1'b0, rb, 1'b0, {4{fail & cmd[0]}}, fail};
        else if (re_q) begin
            dout_r <= col[7:0] ^ pg;
            col <= (col != 527) ? col + 1 : (ptr == 2) ? 10'd512 : 10'd0;
            if (col == 527) pg <= pg + 1;
            if (col == 527) bc <= LOAD_CYC;
        end
    end
endmodule // nfc_dev_model

// file: nfc_ctrl_tb_top.sv
`include "nfc_defines.vh"
module nfc_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fail = 0;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, r;
    logic [31:0] prdata;
    logic        pready, pslverr, e, ce_n, cle, ale, we_n, re_n, rb, oe;
    logic [7:0]  io_o, dq, bus;
    int          bad_count = 0, num_checks = 0, cyc = 0;
    assign bus = oe ? io_o : dq;
    nfc_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
        .prdata(prdata), .nand_ce_n(ce_n), .nand_cle(cle), .nand_ale(ale), .nand_we_n(we_n),
        .output_strobe_n(re_n), .nand_rb(rb), .nand_io_in(bus), .nand_io_out(io_o),
        .nand_io_oe(oe));
    nfc_dev_model u_dev (.pclk(pclk), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
        .re_n(re_n), .din(bus), .fail(fail), .rb(rb), .dout(dq));
    initial forever #10 pclk = ~pclk;
    task automatic end_of_test;
        $display("checks %0d errors %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            bad_count++;
            end_of_test;
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        num_checks++;
        if (g !== x) begin
            bad_count++;
            $display("ERROR %0t got %h exp %h", $time, g, x);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    // Clears done and err first, then polls until done
    task automatic op(input logic [31:0] a, input logic [31:0] c);
        apb(1, `NFC_STAT_OFF, 32'h0000_0006);
        apb(1, `NFC_ADDR_OFF, a);
        apb(1, `NFC_CTRL_OFF, c);
        do apb(0, `NFC_STAT_OFF, 0); while (r[1] !== 1'b1);
    endtask
    task automatic rdbuf(input int n, input int c, input logic [7:0] p);
        int base = (c >= 512) ? 512 : 0;
        apb(1, `NFC_BPTR_OFF, 0);
        for (int i = 0; i < n; i++) begin
            apb(0, `NFC_BDATA_OFF, 0);
            chk(r & 32'h0000_00FF, {24'h0, c[7:0] ^ p});
            p = (c == 527) ? p + 8'h01 : p;
            c = (c == 527) ? base : c + 1;
        end
    endtask
    task automatic t_reset;
        apb(0, `NFC_LEN_OFF, 0);
        chk(r & 32'h0000_03FF, 32'h0000_0210);
        apb(0, `NFC_STAT_OFF, 0);
        chk(r & 32'h0000_00D1, 32'h0000_0010);
        apb(0, 8'h20, 0);
        chk({31'h0, e}, 32'h0000_0001);
    endtask
    task automatic t_reads;
        apb(1, `NFC_LEN_OFF, 32'h0000_0006);
        op(32'h0000_03FE, 32'h0000_0001);
        rdbuf(6, 254, 8'h03);
        apb(1, `NFC_LEN_OFF, 32'h0000_0004);
        op(32'h0000_051E, 32'h0000_0021);
        rdbuf(4, 526, 8'h05);
        op(32'h0000_0705, 32'h0000_0011);
        rdbuf(4, 261, 8'h07);
        op(32'h0000_0805, 32'h0000_0002);
        rdbuf(4, 5, 8'h08);
    endtask
    task automatic t_prog;
        apb(1, `NFC_BPTR_OFF, 0);
        for (int i = 0; i < 4; i++) apb(1, `NFC_BDATA_OFF, 32'h0000_00A0 + i);
        op(32'h0000_0900, 32'h0000_0003);
        chk(r & 32'h00FF_0000, 32'h0040_0000);
        fail <= 1;
        op(32'h0000_0C00, 32'h0000_0003);
        chk(r & 32'h00FF_0000, 32'h0041_0000);
        op(32'h0000_0A00, 32'h0000_0103);
        op(32'h0000_2A00, 32'h0000_0303);
        chk(r & 32'h00FF_0000, 32'h005F_0000);
        fail <= 0;
        op(32'h0000_4000, 32'h0000_0004);
        chk(r & 32'h00FF_0000, 32'h0040_0000);
        apb(1, `NFC_CTRL_OFF, 32'h0000_0113);
        apb(0, `NFC_STAT_OFF, 0);
        chk(r & 32'h0000_0004, 32'h0000_0004);
        apb(1, `NFC_STAT_OFF, 32'h0000_0006);
        apb(1, `NFC_LEN_OFF, 0);
        apb(1, `NFC_CTRL_OFF, 32'h0000_0003);
        apb(0, `NFC_STAT_OFF, 0);
        chk(r & 32'h0000_0007, 32'h0000_0004);
    endtask
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1;
        t_reset;
        t_reads;
        t_prog;
        end_of_test;
    end
endmodule // nfc_ctrl_tb_top
